// File: dcol_device.sv
// Module: device end, decodes host words into two channel holding registers
`timescale 1ns/100ps
module dcol_device (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Host link
  dcol_link_if.device link,
  // Converter side
  output dcol_pkg::dcol_data_t chan1_out,
  output dcol_pkg::dcol_data_t chan2_out,
  output logic refresh_stb
);
  import dcol_pkg::*;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  // Channel positions within the holding array
  localparam int CHAN_FIRST = 0;
  localparam int CHAN_SECOND = 1;

  // What one captured word asks for, from its two select bits
  typedef enum logic [1:0] {
    DCOL_PICK_FIRST,
    DCOL_PICK_SECOND,
    DCOL_PICK_BOTH,
    DCOL_PICK_NONE
  } dcol_pick_e;

  // Select bits are active low
  function automatic dcol_pick_e pick_of(input dcol_points_t w);
    logic first_low;
    logic second_low;
    first_low = ~w[SEL_FIRST_BIT];
    second_low = ~w[SEL_SECOND_BIT];
    if (first_low && second_low) begin
      pick_of = DCOL_PICK_BOTH;
    end else if (first_low) begin
      pick_of = DCOL_PICK_FIRST;
    end else if (second_low) begin
      pick_of = DCOL_PICK_SECOND;
    end else begin
      // Both high: a write that leaves both channels alone
      pick_of = DCOL_PICK_NONE;
    end
  endfunction : pick_of

  function automatic logic chan_hit(input dcol_pick_e p, input int idx);
    case (p)
      DCOL_PICK_BOTH: chan_hit = 1'b1;
      DCOL_PICK_FIRST: chan_hit = (idx == CHAN_FIRST);
      DCOL_PICK_SECOND: chan_hit = (idx == CHAN_SECOND);
      DCOL_PICK_NONE: chan_hit = 1'b0;
      default: chan_hit = 1'b0;
    endcase
  endfunction : chan_hit

  // Unsigned magnitude, bit 0 least significant
  function automatic dcol_data_t data_of(input dcol_points_t w);
    data_of = w[DATA_MSB:DATA_LSB];
  endfunction : data_of

  // ----------------------------------------
  // Word capture
  // ----------------------------------------
  // One register takes the whole word so data and selects stay paired
  dcol_points_t word;
  logic word_valid;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      word <= POINTS_IDLE;
      word_valid <= 1'b0;
    end else begin
      word_valid <= link.write_stb;
      if (link.write_stb) begin
        word <= link.points;
      end
    end
  end

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  dcol_pick_e word_pick;
  assign word_pick = pick_of(word);

  // ----------------------------------------
  // Holding registers
  // ----------------------------------------
  dcol_data_t hold [CHAN_COUNT];
  dcol_data_t next_hold [CHAN_COUNT];
  logic load [CHAN_COUNT];
  genvar gi;
  generate
    for (gi = 0; gi < CHAN_COUNT; gi++) begin : g_hold
      // Several writes per scan each land, so a table host loads both
      assign load[gi] = word_valid && chan_hit(word_pick, gi);
      assign next_hold[gi] = load[gi] ? data_of(word) : hold[gi];
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          hold[gi] <= DATA_RESET;
        end else begin
          hold[gi] <= next_hold[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Scan refresh
  // ----------------------------------------
  // Refresh reads the next holding value, so a write still in capture
  // when scan_stb arrives reaches the outputs in that same scan
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      chan1_out <= DATA_RESET;
      chan2_out <= DATA_RESET;
      refresh_stb <= 1'b0;
    end else begin
      refresh_stb <= link.scan_stb;
      if (link.scan_stb) begin
        chan1_out <= next_hold[CHAN_FIRST];
        chan2_out <= next_hold[CHAN_SECOND];
      end
    end
  end
endmodule : dcol_device

// File: dcol_pkg.sv
// Package: shared constants and types for the dual channel output latch
package dcol_pkg;
  localparam int POINT_COUNT = 32;
  localparam int DATA_WIDTH = 16;
  localparam int CHAN_COUNT = 2;
  localparam int DATA_LSB = 0;
  localparam int DATA_MSB = 15;
  localparam int SEL_FIRST_BIT = 16;
  localparam int SEL_SECOND_BIT = 17;
  localparam int WORD_ALIGN = 16;
  localparam logic [15:0] DATA_RESET = 16'h0000;
  localparam logic [31:0] POINTS_IDLE = 32'hFFFFFFFF;
  typedef logic [POINT_COUNT-1:0] dcol_points_t;
  typedef logic [DATA_WIDTH-1:0] dcol_data_t;
  typedef enum logic [1:0] {DCOL_MODE_MUX, DCOL_MODE_TABLE} dcol_mode_e;
endpackage : dcol_pkg

// File: dcol_link_if.sv
// Interface: 32-point parallel output word from host to module
`timescale 1ns/100ps
interface dcol_link_if;
  import dcol_pkg::*;
  dcol_points_t points;
  logic write_stb;
  logic scan_stb;
  modport host (output points, output write_stb, output scan_stb);
  modport device (input points, input write_stb, input scan_stb);
endinterface : dcol_link_if

// File: dcol_host.sv
// Module: host end, writes channel words over 32 output points each scan
`timescale 1ns/100ps
module dcol_host (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Host link
  dcol_link_if.host link,
  // User side
  input wire logic scan_req,
  input wire dcol_pkg::dcol_mode_e mode,
  input wire logic use_first,
  input wire logic use_second,
  input wire dcol_pkg::dcol_data_t val_first,
  input wire dcol_pkg::dcol_data_t val_second,
  output logic busy
);
  import dcol_pkg::*;

  typedef enum logic [1:0] {DCOL_IDLE, DCOL_WR1, DCOL_WR2, DCOL_SCAN} dcol_state_e;
  dcol_state_e state;
  logic mux_next_second;
  dcol_points_t pts;
  logic wstb;
  logic sstb;
  logic same_val;
  logic shared_word;

  // ----------------------------------------
  // Word build
  // ----------------------------------------
  function automatic dcol_points_t build(input dcol_data_t d, input logic to_first,
    input logic to_second);
    dcol_points_t w;
    w = POINTS_IDLE;
    w[DATA_MSB:DATA_LSB] = d;
    // Select bits are active low
    w[SEL_FIRST_BIT] = ~to_first;
    w[SEL_SECOND_BIT] = ~to_second;
    build = w;
  endfunction : build

  // Equal table values share one word with both selects low
  assign same_val = use_first && use_second && (val_first == val_second);

  assign link.points = pts;
  assign link.write_stb = wstb;
  assign link.scan_stb = sstb;

  // ----------------------------------------
  // Scan sequencer
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= DCOL_IDLE;
      pts <= POINTS_IDLE;
      wstb <= 1'b0;
      sstb <= 1'b0;
      busy <= 1'b0;
      mux_next_second <= 1'b0;
      shared_word <= 1'b0;
    end else begin
      wstb <= 1'b0;
      sstb <= 1'b0;
      case (state)
        DCOL_IDLE: begin
          busy <= scan_req;
          if (scan_req) begin
            state <= DCOL_WR1;
          end
        end
        DCOL_WR1: begin
          if (mode == DCOL_MODE_TABLE) begin
            pts <= build(val_first, 1'b1, same_val);
            wstb <= use_first;
            shared_word <= same_val;
            state <= DCOL_WR2;
          end else begin
            // One channel per scan, alternating when both in use
            if (use_first && (!use_second || !mux_next_second)) begin
              pts <= build(val_first, 1'b1, 1'b0);
              wstb <= 1'b1;
              mux_next_second <= use_second;
            end else if (use_second) begin
              pts <= build(val_second, 1'b0, 1'b1);
              wstb <= 1'b1;
              mux_next_second <= 1'b0;
            end
            state <= DCOL_SCAN;
          end
        end
        DCOL_WR2: begin
          pts <= build(val_second, 1'b0, 1'b1);
          wstb <= use_second && !shared_word;
          state <= DCOL_SCAN;
        end
        DCOL_SCAN: begin
          sstb <= 1'b1;
          busy <= 1'b0;
          state <= DCOL_IDLE;
        end
        default: state <= DCOL_IDLE;
      endcase
    end
  end
endmodule : dcol_host

// File: dcol_props.sv
// Link checker
`timescale 1ns/100ps
module dcol_props (
  // Clock
  input wire logic core_clk,
  input wire logic rst_n,
  // Link
  input wire dcol_pkg::dcol_points_t points,
  input wire logic write_stb,
  input wire logic scan_stb
);
  import dcol_pkg::*;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  property p_pad; points[POINT_COUNT-1:18] == 14'h3FFF; endproperty
  a_pad: assert property (p_pad) else $error("pad low");
  property p_sel; write_stb |-> !(&points[17:16]); endproperty
  a_sel: assert property (p_sel) else $error("no chan");
  property p_excl; !(write_stb && scan_stb); endproperty
  a_excl: assert property (p_excl) else $error("overlap");
  property p_ws; write_stb |-> ##[1:2] scan_stb; endproperty
  a_ws: assert property (p_ws) else $error("no scan");
  property p_sp; scan_stb |=> !scan_stb; endproperty
  a_sp: assert property (p_sp) else $error("long scan");
  property p_two; write_stb [*2] |=> !write_stb; endproperty
  a_two: assert property (p_two) else $error("3 writes");
  property p_pair; write_stb [*2] |-> points[17] != $past(points[17]); endproperty
  a_pair: assert property (p_pair) else $error("same chan");
  property p_new; scan_stb |-> $past(write_stb) || $past(write_stb, 2); endproperty
  a_new: assert property (p_new) else $error("stale");
endmodule : dcol_props

// File: dual_channel_output_latch_bench.sv
// Bench joining host and device ends
`timescale 1ns/100ps
module dual_channel_output_latch_bench;
  import dcol_pkg::*;
  logic core_clk = 1'b0, rst_n = 1'b0, scan_req = 1'b0, refresh_stb, busy;
  logic [1:0] sel = 2'h3, ns = 2'h3;
  dcol_mode_e mode = DCOL_MODE_MUX, nm = DCOL_MODE_MUX;
  dcol_data_t vf = 16'h0000, vs = 16'h0000, chan1_out, chan2_out, e1 = 16'h0000, e2 = 16'h0000;
  dcol_data_t nf = 16'h0000, nv = 16'h0000;
  int errors = 0, cmp_count = 0, seed = 32'hE5E3, need = 1;
  dcol_link_if link ();
  dcol_host dcol_host_i (.core_clk, .rst_n, .link(link.host), .scan_req, .mode,
    .use_first(sel[0]), .use_second(sel[1]), .val_first(vf), .val_second(vs), .busy);
  dcol_device dcol_device_i (.core_clk, .rst_n, .link(link.device), .chan1_out, .chan2_out,
    .refresh_stb);
  dcol_props dcol_props_i (.core_clk, .rst_n, .points(link.points),
    .write_stb(link.write_stb), .scan_stb(link.scan_stb));
  initial forever #12.5 core_clk = ~core_clk;
  task automatic report_and_stop;
    if (errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(dcol_data_t g, x);
    cmp_count++;
    if (g !== x) begin
      errors++;
      $display("MISMATCH %0t %h %h", $time, g, x);
    end
  endtask : chk
  task automatic chk_bit(logic g, x);
    cmp_count++;
    if (g !== x) begin
      errors++;
      $display("MISMATCH %0t %h %h", $time, g, x);
    end
  endtask : chk_bit
  function automatic dcol_data_t pick(logic u, dcol_data_t v, o);
    return u ? v : o;
  endfunction : pick
  task automatic scan;
    @(posedge core_clk) scan_req <= 1'b1;
    @(posedge core_clk) scan_req <= 1'b0;
    @(negedge core_clk);
    chk_bit(busy, 1'b1);
    repeat (20) if (refresh_stb !== 1'b1) @(negedge core_clk);
    if (refresh_stb !== 1'b1) begin
      errors++;
      report_and_stop();
    end else begin
      chk_bit(busy, 1'b0);
      @(negedge core_clk);
      chk_bit(refresh_stb, 1'b0);
    end
  endtask : scan
  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    @(negedge core_clk);
    chk(chan1_out, e1);
    chk(chan2_out, e2);
    for (int i = 0; i < 40; i++) begin
      // First pass loads distinct extremes, second shares one table value
      ns = (i < 2) ? 2'h3 : 2'({$random(seed)} % 3 + 1);
      nf = (i == 0) ? 16'hFFFF : 16'($random(seed));
      nv = (i == 0) ? 16'h0001 : (i == 1) ? nf : 16'($random(seed));
      nm = (i == 1) ? DCOL_MODE_TABLE : dcol_mode_e'($random(seed) & 1);
      @(posedge core_clk);
      sel <= ns;
      vf <= nf;
      vs <= nv;
      mode <= nm;
      e1 = pick(ns[0], nf, e1);
      e2 = pick(ns[1], nv, e2);
      // Multiplexed host needs one scan per channel in use
      need = (nm == DCOL_MODE_MUX && ns == 2'h3) ? 2 : 1;
      repeat (need) scan();
      chk(chan1_out, e1);
      chk(chan2_out, e2);
      scan();
      chk(chan1_out, e1);
      chk(chan2_out, e2);
    end
    report_and_stop();
  end
endmodule : dual_channel_output_latch_bench
